/* core/epw_host.sv */
`timescale 1ns/1ps
module epw_host (
    // clock and reset
    input  wire logic                            mclk,
    input  wire logic                            nrst,
    // user request
    input  wire logic                            req_read,
    input  wire logic                            req_write,
    input  wire logic                            req_protect,
    input  wire logic [epw_pkg::ADDR_W-1:0]      req_addr,
    input  wire logic [epw_pkg::CNT_W-1:0]       req_len,
    input  wire logic [epw_pkg::DATA_W-1:0]      wr_byte,
    output logic                                 wr_take,
    output logic                                 busy,
    output logic                                 rd_valid,
    output logic [epw_pkg::DATA_W-1:0]           rd_byte,
    output logic                                 done,
    // device pins
    output logic [epw_pkg::ADDR_W-1:0]           byte_address,
    output logic                                 sel_n,
    output logic                                 gate_n,
    output logic                                 strobe_n,
    input  wire logic [epw_pkg::DATA_W-1:0]      data_lines_i,
    output logic [epw_pkg::DATA_W-1:0]           data_lines_o,
    output logic                                 data_lines_oe
);
    epw_pkg::epw_state_t        st_q, st_d;
    logic [epw_pkg::TMR_W-1:0]  tmr_q, tmr_d;
    logic [epw_pkg::CNT_W-1:0]  left_q, left_d;
    logic [1:0]                 unl_q, unl_d;
    logic                       prot_q, prot_d;
    logic                       rd_q, rd_d;
    logic [epw_pkg::ADDR_W-1:0] a_q, a_d;
    logic [epw_pkg::ADDR_W-1:0] ua_q, ua_d;
    logic [epw_pkg::DATA_W-1:0] d_q, d_d;
    logic [epw_pkg::DATA_W-1:0] last_q, last_d;
    logic [epw_pkg::DATA_W-1:0] rb_q, rb_d;
    logic [epw_pkg::DATA_W-1:0] prev_q, prev_d;
    logic                       wt_q, wt_d;
    logic                       rv_q, rv_d;
    logic                       dn_q, dn_d;
    logic                       bz_q, bz_d;
    logic                       sn_q, sn_d;
    logic                       gn_q, gn_d;
    logic                       wn_q, wn_d;
    logic                       oe_q, oe_d;
    logic                       pf_q, pf_d;
    logic                       unl_on;
    logic [epw_pkg::DATA_W-1:0] s1_q, s2_q;
    logic [epw_pkg::TMR_W-1:0]  ph_cyc;
    logic [epw_pkg::TMR_W-1:0]  rd_cyc;
    logic [epw_pkg::TMR_W-1:0]  st_cyc;
    logic [epw_pkg::CNT_W-1:0]  pg_max;
    assign ph_cyc = epw_pkg::TMR_W'(epw_pkg::T_PHASE_CYC);
    assign rd_cyc = epw_pkg::TMR_W'(epw_pkg::T_PHASE_CYC + epw_pkg::T_RD_EXTRA);
    assign st_cyc = epw_pkg::TMR_W'(epw_pkg::T_START_CYC);
    assign pg_max = epw_pkg::CNT_W'(epw_pkg::PAGE_BYTES);
    // unlock prefix still to send
    assign unl_on = prot_q && (unl_q != epw_pkg::UNL_LAST);

    // bytes of the unlock prefix
    function automatic logic [epw_pkg::ADDR_W+epw_pkg::DATA_W-1:0] unl_word(input logic [1:0] i);
        case (i)
            2'h0:    unl_word = {epw_pkg::UNL_A0, epw_pkg::UNL_D0};
            2'h1:    unl_word = {epw_pkg::UNL_A1, epw_pkg::UNL_D1};
            default: unl_word = {epw_pkg::UNL_A0, epw_pkg::UNL_D2};
        endcase
    endfunction : unl_word

    always_comb begin
        st_d   = st_q;
        tmr_d  = tmr_q + 1'b1;
        left_d = left_q;
        unl_d  = unl_q;
        prot_d = prot_q;
        rd_d   = rd_q;
        a_d    = a_q;
        ua_d   = ua_q;
        d_d    = d_q;
        last_d = last_q;
        rb_d   = rb_q;
        prev_d = prev_q;
        wt_d   = 1'b0;
        rv_d   = 1'b0;
        dn_d   = 1'b0;
        bz_d   = bz_q;
        pf_d   = pf_q;
        sn_d   = sn_q;
        gn_d   = gn_q;
        wn_d   = wn_q;
        oe_d   = oe_q;
        case (st_q)
            epw_pkg::ST_IDLE: begin
                sn_d = 1'b1; // R17
                gn_d = 1'b1;
                wn_d = 1'b1;
                oe_d = 1'b0; // R3
                bz_d = 1'b0;
                if (req_write) begin
                    bz_d   = 1'b1;
                    prot_d = req_protect;
                    unl_d  = 2'h0;
                    rd_d   = 1'b0;
                    a_d    = req_addr;
                    ua_d   = req_addr;
                    left_d = (req_len == '0) ? 8'h01 : req_len; // R10
                    if (req_len > pg_max) begin
                        left_d = pg_max; // R8
                    end
                    st_d   = epw_pkg::ST_SETUP;
                    tmr_d  = '0;
                end else if (req_read) begin
                    bz_d   = 1'b1;
                    rd_d   = 1'b1;
                    a_d    = req_addr;
                    st_d   = epw_pkg::ST_RD;
                    tmr_d  = '0;
                end
            end
            epw_pkg::ST_SETUP: begin
                // address and data settle while gate stays high
                if (unl_on) begin
                    {a_d, d_d} = unl_word(unl_q); // R20
                end else if (tmr_q == '0) begin
                    // one take per data byte, user address back on the pins
                    a_d    = ua_q;
                    d_d    = wr_byte;
                    last_d = wr_byte;
                    wt_d   = 1'b1;
                end
                gn_d = 1'b1; // R19
                sn_d = 1'b0;
                oe_d = 1'b1;
                if (tmr_q >= ph_cyc) begin
                    wn_d  = 1'b0; // R4 R5
                    st_d  = epw_pkg::ST_STRB;
                    tmr_d = '0;
                end
            end
            epw_pkg::ST_STRB: begin
                if (tmr_q >= ph_cyc) begin
                    wn_d  = 1'b1; // R6
                    st_d  = epw_pkg::ST_HOLD;
                    tmr_d = '0;
                end
            end
            epw_pkg::ST_HOLD: begin
                if (tmr_q >= ph_cyc) begin
                    sn_d  = 1'b1;
                    oe_d  = 1'b0;
                    st_d  = epw_pkg::ST_GAP;
                    tmr_d = '0;
                    if (unl_on) begin
                        unl_d = unl_q + 1'b1;
                    end else begin
                        left_d = left_q - 1'b1;
                        // low bits wrap, page bits stay
                        ua_d[epw_pkg::PAGE_LO-1:0] = ua_q[epw_pkg::PAGE_LO-1:0] + 1'b1; // R9
                    end
                end
            end
            epw_pkg::ST_GAP: begin
                if (left_q != '0 || unl_on) begin
                    st_d  = epw_pkg::ST_SETUP; // R11 R8
                    tmr_d = '0;
                end else if (tmr_q >= st_cyc) begin
                    // past the load window, so programming has begun; pins hold last byte
                    st_d  = epw_pkg::ST_POLL; // R12
                    tmr_d = '0;
                    pf_d  = 1'b0;
                end
            end
            epw_pkg::ST_POLL: begin
                sn_d = 1'b0; // R1
                gn_d = 1'b0;
                wn_d = 1'b1;
                oe_d = 1'b0;
                if (tmr_q >= rd_cyc) begin
                    st_d  = epw_pkg::ST_PREAD;
                    tmr_d = '0;
                end
            end
            epw_pkg::ST_PREAD: begin
                sn_d = 1'b1; // R2
                gn_d = 1'b1;
                if (tmr_q == '0) begin
                    prev_d = s2_q;
                    pf_d   = 1'b1;
                    if (pf_q && prev_q[epw_pkg::TOG_BIT] == s2_q[epw_pkg::TOG_BIT]
                        && s2_q[epw_pkg::POLL_BIT] == last_q[epw_pkg::POLL_BIT]) begin
                        st_d = epw_pkg::ST_RDONE; // R13 R14 R15 R16 R21 R7
                    end
                end else if (tmr_q >= ph_cyc) begin
                    st_d  = epw_pkg::ST_POLL;
                    tmr_d = '0;
                end
            end
            epw_pkg::ST_RD: begin
                sn_d = 1'b0; // R1 R18
                gn_d = 1'b0;
                wn_d = 1'b1;
                oe_d = 1'b0;
                if (tmr_q >= rd_cyc) begin
                    rb_d  = s2_q;
                    sn_d  = 1'b1;
                    gn_d  = 1'b1;
                    st_d  = epw_pkg::ST_RDONE;
                    tmr_d = '0;
                end
            end
            epw_pkg::ST_RDONE: begin
                sn_d = 1'b1;
                gn_d = 1'b1;
                if (tmr_q >= ph_cyc) begin
                    rv_d = rd_q;
                    dn_d = 1'b1;
                    bz_d = 1'b0;
                    st_d = epw_pkg::ST_IDLE;
                end
            end
            default: begin
                st_d = epw_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st_q   <= epw_pkg::ST_IDLE;
            tmr_q  <= '0;
            left_q <= '0;
            unl_q  <= '0;
            prot_q <= 1'b0;
            rd_q   <= 1'b0;
            a_q    <= '0;
            ua_q   <= '0;
            d_q    <= '0;
            last_q <= '0;
            rb_q   <= '0;
            prev_q <= '0;
            wt_q   <= 1'b0;
            rv_q   <= 1'b0;
            dn_q   <= 1'b0;
            bz_q   <= 1'b0;
            pf_q   <= 1'b0;
            sn_q   <= 1'b1;
            gn_q   <= 1'b1;
            wn_q   <= 1'b1;
            oe_q   <= 1'b0;
            s1_q   <= '0;
            s2_q   <= '0;
        end else begin
            st_q   <= st_d;
            tmr_q  <= tmr_d;
            left_q <= left_d;
            unl_q  <= unl_d;
            prot_q <= prot_d;
            rd_q   <= rd_d;
            a_q    <= a_d;
            ua_q   <= ua_d;
            d_q    <= d_d;
            last_q <= last_d;
            rb_q   <= rb_d;
            prev_q <= prev_d;
            wt_q   <= wt_d;
            rv_q   <= rv_d;
            dn_q   <= dn_d;
            bz_q   <= bz_d;
            pf_q   <= pf_d;
            sn_q   <= sn_d;
            gn_q   <= gn_d;
            wn_q   <= wn_d;
            oe_q   <= oe_d;
            s1_q   <= data_lines_i;
            s2_q   <= s1_q;
        end
    end

    assign wr_take       = wt_q;
    assign busy          = bz_q;
    assign rd_valid      = rv_q;
    assign rd_byte       = rb_q;
    assign done          = dn_q;
    assign byte_address  = a_q;
    assign sel_n         = sn_q;
    assign gate_n        = gn_q;
    assign strobe_n      = wn_q;
    assign data_lines_o  = d_q;
    assign data_lines_oe = oe_q;
endmodule : epw_host

/* core/epw_pkg.sv */
// What the device document says
// [R1] reads drive output gate and chip select low together
// [R2] read ends when select or output gate returns high
// [R3] device floats data lines while gate or select high; host drives only in writes
// [R4] write: select and strobe low while output gate high
// [R5] device latches address at later falling edge of select or strobe
// [R6] device latches data at earlier rising edge of select or strobe
// [R7] single byte write completes on device timing, about 3 ms
// [R8] device buffers up to 128 byte loads before programming
// [R9] host keeps page address bits 14..7 same through a page load
// [R10] after first load, one to 127 more bytes by same strobe sequence
// [R11] host gives next strobe fall within 100 us of previous
// [R12] device starts programming after 100 us without strobe fall
// [R13] during programming, bit 7 of last byte reads complemented
// [R14] after programming, bit 7 reads true data
// [R15] during programming, bit 6 toggles on each read
// [R16] toggling stops when done; normal access resumes
// [R17] every access needs chip select low; high means standby
// [R18] fifteen address bits select one of 32K bytes
// [R19] output gate low, strobe high or select high blocks writes
// [R20] protected mode: three-write unlock opens one page load
// [R21] programming time is a configurable count, array busy meanwhile
package epw_pkg;
    localparam int          CLK_MHZ      = 125;
    localparam int          ADDR_W       = 15;
    localparam int          DATA_W       = 8;
    localparam int          PAGE_LO      = 7;
    localparam int          PAGE_BYTES   = 128;
    localparam int          CNT_W        = 8;
    // strobe phase timings, ns
    localparam int          T_PHASE_NS   = 80;
    localparam int          T_PHASE_CYC  = (T_PHASE_NS * CLK_MHZ + 999) / 1000;
    // byte load window, us, with a half-window margin kept above it
    localparam int          T_LOAD_US    = 100;
    localparam int          T_LOAD_CYC   = (T_LOAD_US * CLK_MHZ) / 2;
    // wait after the last load: whole window plus margin, so polls see programming
    localparam int          T_START_CYC  = T_LOAD_US * CLK_MHZ + T_LOAD_CYC;
    // extra read cycles covering the data synchroniser
    localparam int          T_RD_EXTRA   = 3;
    localparam int          TMR_W        = 16;
    localparam int          POLL_BIT     = 7;
    localparam int          TOG_BIT      = 6;
    // unlock sequence
    localparam logic [14:0] UNL_A0       = 15'h5555;
    localparam logic [14:0] UNL_A1       = 15'h2AAA;
    localparam logic [7:0]  UNL_D0       = 8'hAA;
    localparam logic [7:0]  UNL_D1       = 8'h55;
    localparam logic [7:0]  UNL_D2       = 8'hA0;
    localparam logic [1:0]  UNL_LAST     = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_SETUP = 4'b0001,
        ST_STRB  = 4'b0011,
        ST_HOLD  = 4'b0010,
        ST_GAP   = 4'b0110,
        ST_POLL  = 4'b0111,
        ST_PREAD = 4'b0101,
        ST_RD    = 4'b0100,
        ST_RDONE = 4'b1100
    } epw_state_t;
endpackage : epw_pkg

/* tb/epw_dev.sv */
`timescale 1ns/1ps
module epw_dev #(
    parameter int T_LOAD_NS = 100000,
    parameter int T_PROG_NS = 100000
) (
    input wire logic [14:0] byte_address,
    input wire logic        sel_n, gate_n, strobe_n,
    input wire logic [7:0]  din,
    output logic [7:0]      dq
);
    logic [7:0]  mem [0:32767];
    logic [7:0]  last_d = 8'h00, held = 8'h00, val;
    logic [14:0] wa, last_a = 15'h0000;
    logic        prog = 1'b0, tog = 1'b0, wr = 1'b0, pend = 1'b0;
    realtime     t_fall = 0;
    wire         ren = !sel_n && !gate_n;
    initial for (int i = 0; i < 32768; i++) mem[i] = i[7:0] ^ i[14:7];
    always @(negedge sel_n or negedge strobe_n)
        if (!sel_n && !strobe_n && gate_n && !prog) begin
            wr = 1'b1;
            wa = byte_address;
            t_fall = $realtime;
            pend = 1'b1;
        end
    always @(posedge sel_n or posedge strobe_n)
        if (wr) begin
            wr = 1'b0;
            mem[wa] = din;
            last_a = wa;
            last_d = din;
        end
    always #1000 if (pend && $realtime - t_fall >= T_LOAD_NS) begin
        pend = 1'b0;
        prog = 1'b1;
        #(T_PROG_NS) prog = 1'b0;
    end
    always @(posedge ren) if (prog) tog = ~tog;
    always @* val = !prog ? mem[byte_address] : {byte_address == last_a ? ~last_d[7] :
        mem[byte_address][7], tog, mem[byte_address][5:0]};
    always @(negedge ren) held = val;
    assign dq = ren ? val : ~held;
endmodule : epw_dev

/* tb/epw_host_asserts.sv */
`timescale 1ns/1ps
module epw_chk (
    // clock and reset
    input wire logic                        mclk, nrst,
    // user side
    input wire logic                        wr_take, busy, rd_valid, done,
    // device pins
    input wire logic [epw_pkg::ADDR_W-1:0]  byte_address,
    input wire logic                        sel_n, gate_n, strobe_n, data_lines_oe,
    input wire logic [epw_pkg::DATA_W-1:0]  data_lines_o
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic [13:0] gap_q;
    always_ff @(posedge mclk)
        gap_q <= (!busy || $fell(strobe_n)) ? 14'h0000 : gap_q + 14'h0001;
    read_select_a: assert property (!gate_n |-> !sel_n && strobe_n)
        else $error("gate low outside a select");
    write_cond_a: assert property (!strobe_n |-> !sel_n && gate_n && data_lines_oe)
        else $error("strobe low outside a write");
    bus_float_a: assert property (!gate_n |-> !data_lines_oe)
        else $error("host drives data during read");
    addr_hold_a: assert property (!strobe_n |=> $stable(byte_address))
        else $error("address moved at strobe");
    data_hold_a: assert property (!strobe_n |=> $stable(data_lines_o))
        else $error("data moved at strobe");
    load_gap_a: assert property ($fell(strobe_n) |-> gap_q < 14'd12500)
        else $error("byte load gap too long");
    idle_pins_a: assert property (!busy |-> sel_n && strobe_n)
        else $error("pins active while idle");
    take_pulse_a: assert property (wr_take |=> !wr_take)
        else $error("byte take not a pulse");
    cover property ($fell(strobe_n));
    cover property (rd_valid);
    cover property (done && !rd_valid);
endmodule : epw_chk
bind epw_host epw_chk u_chk (.mclk, .nrst, .wr_take, .busy, .rd_valid, .done,
    .byte_address, .sel_n, .gate_n, .strobe_n, .data_lines_oe, .data_lines_o);

/* tb/epw_host_tb.sv */
`timescale 1ns/1ps
module epw_host_tb;
    logic        mclk = 1'b0, nrst = 1'b0, req_read = 1'b0, req_write = 1'b0;
    logic        req_protect = 1'b0, wr_take, busy, rd_valid, done;
    logic        sel_n, gate_n, strobe_n, data_lines_oe;
    logic [14:0] req_addr = 15'h0000, byte_address;
    logic [7:0]  req_len = 8'h00, wr_byte = 8'h00, rd_byte, data_lines_i, data_lines_o, dq;
    logic [7:0]  wq [$];
    int          error_cnt = 0, checks = 0;
    always #4 mclk = ~mclk;
    assign data_lines_i = data_lines_oe ? data_lines_o : dq;
    epw_host dut (.mclk, .nrst, .req_read, .req_write, .req_protect, .req_addr, .req_len,
        .wr_byte, .wr_take, .busy, .rd_valid, .rd_byte, .done, .byte_address, .sel_n,
        .gate_n, .strobe_n, .data_lines_i, .data_lines_o, .data_lines_oe);
    epw_dev dev (.byte_address, .sel_n, .gate_n, .strobe_n,
        .din(data_lines_oe ? data_lines_o : ~data_lines_o), .dq);
    always @(negedge mclk) if (wr_take === 1'b1 && wq.size() > 0) wr_byte <= wq.pop_front();
    function automatic logic [7:0] pat(input logic [14:0] a);
        return a[7:0] ^ a[14:7];
    endfunction : pat
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wait_done();
        repeat (60000) begin
            @(posedge mclk);
            #1;
            if (done === 1'b1) break;
        end
        cmp({7'h00, done}, 8'h01);
    endtask : wait_done
    task automatic do_rd(input logic [14:0] a, input logic [7:0] exp);
        @(negedge mclk);
        req_addr = a;
        req_read = 1'b1;
        @(negedge mclk);
        req_read = 1'b0;
        wait_done();
        cmp({7'h00, rd_valid}, 8'h01);
        cmp(rd_byte, exp);
    endtask : do_rd
    task automatic do_wr(input logic [14:0] a, input logic [7:0] n, input logic p);
        @(negedge mclk);
        wr_byte = wq.pop_front();
        req_addr = a;
        req_len = n;
        req_protect = p;
        req_write = 1'b1;
        @(negedge mclk);
        req_write = 1'b0;
        req_protect = 1'b0;
        wait_done();
    endtask : do_wr
    task automatic t_reset();
        cmp({4'h0, sel_n, gate_n, strobe_n, data_lines_oe}, 8'h0E);
    endtask : t_reset
    task automatic t_read();
        do_rd(15'h1234, pat(15'h1234));
    endtask : t_read
    task automatic t_page();
        wq = '{8'h11, 8'h82, 8'h7F};
        do_wr(15'h0AFE, 8'h03, 1'b0);
        do_rd(15'h0AFE, 8'h11);
        do_rd(15'h0AFF, 8'h82);
        do_rd(15'h0A80, 8'h7F);
        do_rd(15'h0A81, pat(15'h0A81));
    endtask : t_page
    task automatic t_prot();
        wq = '{8'h3C};
        do_wr(15'h4000, 8'h00, 1'b1);
        do_rd(15'h4000, 8'h3C);
    endtask : t_prot
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (8) @(negedge mclk);
        nrst = 1'b1;
        t_reset();
        t_read();
        t_page();
        t_prot();
        report_and_stop();
    end
    initial begin
        #800us;
        error_cnt++;
        report_and_stop();
    end
endmodule : epw_host_tb
